// ===== rtl/flb_regs.svh
// Offsets, the reserved byte value and timing counts for the fault-log block readout
`ifndef FLB_REGS_SVH
`define FLB_REGS_SVH
// -----------------------------------------------------------------------------
// Block layout (byte indices)
// -----------------------------------------------------------------------------
`define FLB_IDX_PTR        8'h00
`define FLB_IDX_TICK       8'h01
`define FLB_IDX_TICK_TOP   8'h06
`define FLB_IDX_CH0        8'h07
`define FLB_IDX_INPUT      8'h13
`define FLB_IDX_CH1        8'h1F
`define FLB_IDX_CH2        8'h2B
`define FLB_IDX_CH3        8'h37
`define FLB_IDX_STATUS     8'h43
`define FLB_IDX_CYCLIC     8'h4F
`define FLB_IDX_RESERVED   8'hEE
`define FLB_IDX_LAST       8'hFE
`define FLB_PREAMBLE_BITS  632
`define FLB_REC_LAST_POS   6'h39
`define FLB_RESERVED_BYTE  8'h00
// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define FLB_CLK_MHZ        25
`define FLB_TICK_US        200
`define FLB_TICK_CYCLES    (`FLB_TICK_US * `FLB_CLK_MHZ)
`endif

// ===== rtl/flb_pkg.sv
// Types shared by the fault-log block readout
package flb_pkg;
  // Readout sequencer states
  typedef enum logic {
    FLB_IDLE,
    FLB_SEND
  } flb_state_type;
endpackage : flb_pkg

// ===== rtl/flb_readout.sv
// Fault-log block snapshot, byte sequencer and output FIFO
// Notes on behaviour
// - Byte 0 is the captured record pointer
// - Bytes 1-6 carry 41-bit tick stamp, LSB first
// - Tick counter advances once per 200 us
// - Bytes 7-18 hold channel 0 extremes
// - Bytes 19-30 hold input extremes
// - Channels 1-3 extremes at 31, 43, 55
// - Bytes 67-78 hold three status bytes per channel
// - Preamble is 79 bytes; cyclic data follows
// - Cyclic bytes walk down from captured pointer
// - Bytes 238-254 are reserved, read zero
// - Byte 0 goes out first in the read
// - Read-only block of exactly 255 bytes
// - Record has 58 positions, read decrementing
// - Lock clears only on completed block read
`include "flb_regs.svh"

// -----------------------------------------------------------------------------
// Output FIFO with registered head
// -----------------------------------------------------------------------------
module flb_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          ov_r, ov_nxt;
  logic [W-1:0]  od_r, od_nxt;
  logic          push, pop;

  // Head register keeps the top outputs straight from flops
  always_comb begin
    push    = in_valid_i && (cnt_r < (AW+1)'(DEPTH));
    pop     = (cnt_r != '0) && (!ov_r || out_ready_i);
    wr_nxt  = push ? ((wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1) : wr_r;
    rd_nxt  = pop ? ((rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1) : rd_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    ov_nxt  = pop ? 1'b1 : (out_ready_i ? 1'b0 : ov_r);
    od_nxt  = pop ? mem[rd_r] : od_r;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
      ov_r  <= 1'b0;
      od_r  <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
      ov_r  <= ov_nxt;
      od_r  <= od_nxt;
    end
  end

  // Storage needs no reset; only words counted as held are ever read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_r] <= in_data_i;
    end
  end

  assign in_ready_o  = cnt_r < (AW+1)'(DEPTH);
  assign out_valid_o = ov_r;
  assign out_data_o  = od_r;
endmodule : flb_fifo

// -----------------------------------------------------------------------------
// Top: snapshot capture, tick counter, lock flag, byte sequencer
// -----------------------------------------------------------------------------
module flb_readout #(
  parameter int TICK_CYCLES = `FLB_TICK_CYCLES,
  parameter int FIFO_DEPTH  = 8
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rstn_i,
  input  wire logic         rec_wr_i,
  input  wire logic [5:0]   rec_pos_i,
  input  wire logic [7:0]   rec_data_i,
  input  wire logic         fault_i,
  input  wire logic [7:0]   fault_ptr_i,
  input  wire logic [383:0] chan_ext_i,
  input  wire logic [95:0]  input_ext_i,
  input  wire logic [95:0]  chan_status_i,
  input  wire logic         restore_done_i,
  input  wire logic         read_start_i,
  output logic [7:0]        byte_o,
  output logic              byte_valid_o,
  output logic              byte_last_o,
  input  wire logic         byte_ready_i,
  output logic              busy_o,
  output logic              read_done_o,
  output logic              ram_lock_o
);
  logic rst_s1_r, rst_n;
  logic [7:0]  rec_mem [58];
  logic [`FLB_PREAMBLE_BITS-1:0] pre_r, pre_nxt;
  logic [40:0] tick_r, tick_nxt;
  logic [12:0] div_r, div_nxt;
  logic        tick_en;
  logic        lock_r, lock_nxt, done_r, done_nxt;
  flb_pkg::flb_state_type st_r, st_nxt;
  logic [7:0]  idx_r, idx_nxt;
  logic [5:0]  pos_r, pos_nxt;
  logic [7:0]  sel_byte;
  logic        fifo_rdy, push, out_v, out_last;
  logic [7:0]  out_d;

  // Reset release through two flops
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // Cyclic record; frozen while locked so a restored log survives
  always_ff @(posedge clk_sys_i) begin
    if (rec_wr_i && !lock_r && rec_pos_i <= `FLB_REC_LAST_POS) begin
      rec_mem[rec_pos_i] <= rec_data_i;
    end
  end

  // Tick divider and shared tick counter
  always_comb begin
    tick_en  = (div_r == 13'(TICK_CYCLES - 1));
    div_nxt  = tick_en ? '0 : div_r + 1'b1;
    tick_nxt = tick_en ? tick_r + 41'h1 : tick_r;
  end

  // Snapshot layout, byte 0 in the low bits
  always_comb begin
    pre_nxt = pre_r;
    if (fault_i && !lock_r) begin
      pre_nxt = {chan_status_i,
                 chan_ext_i[383:96],
                 input_ext_i,
                 chan_ext_i[95:0],
                 7'h00, tick_r,
                 fault_ptr_i};
    end
  end

  // Lock: set by a restore, cleared by a finished read; set wins
  always_comb begin
    done_nxt = out_v && byte_ready_i && out_last;
    if (restore_done_i) begin
      lock_nxt = 1'b1;
    end else if (done_r) begin
      lock_nxt = 1'b0;
    end else begin
      lock_nxt = lock_r;
    end
  end

  // Byte selection for the current index
  always_comb begin
    if (idx_r < `FLB_IDX_CYCLIC) begin
      sel_byte = pre_r[idx_r*8 +: 8];
    end else if (idx_r < `FLB_IDX_RESERVED) begin
      sel_byte = rec_mem[pos_r];
    end else begin
      sel_byte = `FLB_RESERVED_BYTE;
    end
  end

  // Sequencer: one byte per free FIFO slot, 255 bytes in all
  always_comb begin
    st_nxt  = st_r;
    idx_nxt = idx_r;
    pos_nxt = pos_r;
    push    = 1'b0;
    case (st_r)
      flb_pkg::FLB_IDLE: begin
        if (read_start_i) begin
          st_nxt  = flb_pkg::FLB_SEND;
          idx_nxt = `FLB_IDX_PTR;
          pos_nxt = pre_r[5:0];
        end
      end
      flb_pkg::FLB_SEND: begin
        push = fifo_rdy;
        if (fifo_rdy) begin
          idx_nxt = idx_r + 8'h01;
          if (idx_r >= `FLB_IDX_CYCLIC) begin
            pos_nxt = (pos_r == 6'h00) ? `FLB_REC_LAST_POS
                                       : pos_r - 6'h01;
          end
          if (idx_r == `FLB_IDX_LAST) begin
            st_nxt = flb_pkg::FLB_IDLE;
          end
        end
      end
      default: st_nxt = flb_pkg::FLB_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      div_r  <= '0;
      tick_r <= '0;
      pre_r  <= '0;
      lock_r <= 1'b0;
      done_r <= 1'b0;
      st_r   <= flb_pkg::FLB_IDLE;
      idx_r  <= '0;
      pos_r  <= '0;
    end else begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
      pre_r  <= pre_nxt;
      lock_r <= lock_nxt;
      done_r <= done_nxt;
      st_r   <= st_nxt;
      idx_r  <= idx_nxt;
      pos_r  <= pos_nxt;
    end
  end

  // Host may stall; FIFO back-pressure holds the sequencer
  flb_fifo #(.W(9), .DEPTH(FIFO_DEPTH), .AW($clog2(FIFO_DEPTH))) u_fifo (
    .clk_i       (clk_sys_i),
    .rst_n_i     (rst_n),
    .in_valid_i  (push),
    .in_ready_o  (fifo_rdy),
    .in_data_i   ({idx_r == `FLB_IDX_LAST, sel_byte}),
    .out_valid_o (out_v),
    .out_ready_i (byte_ready_i),
    .out_data_o  ({out_last, out_d})
  );

  assign byte_o       = out_d;
  assign byte_valid_o = out_v;
  assign byte_last_o  = out_last;
  assign busy_o       = (st_r == flb_pkg::FLB_SEND);
  assign read_done_o  = done_r;
  assign ram_lock_o   = lock_r;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);

  property p_ptr_byte;
    push && idx_r == `FLB_IDX_PTR |-> sel_byte == pre_r[7:0];
  endproperty
  a_ptr_byte: assert property (p_ptr_byte) else $error("byte 0 not pointer");
  // Capture must take the live pointer, not a stale one
  property p_capture;
    fault_i && !lock_r |=> pre_r[7:0] == $past(fault_ptr_i);
  endproperty
  a_capture: assert property (p_capture) else $error("pointer not captured");
  property p_tick_top;
    push && idx_r == `FLB_IDX_TICK_TOP |-> sel_byte[7:1] == 7'h00;
  endproperty
  a_tick_top: assert property (p_tick_top) else $error("tick top byte wide");
  property p_tick_step;
    tick_en |=> tick_r == $past(tick_r) + 41'h1 && div_r == 13'h0;
  endproperty
  a_tick_step: assert property (p_tick_step) else $error("tick step wrong");
  property p_tick_hold;
    !tick_en |=> tick_r == $past(tick_r);
  endproperty
  a_tick_hold: assert property (p_tick_hold) else $error("tick moved early");
  property p_start_first;
    st_r == flb_pkg::FLB_IDLE && read_start_i |=> idx_r == 8'h00 && busy_o;
  endproperty
  a_start_first: assert property (p_start_first) else $error("read not at 0");
  property p_cyc_first;
    push && idx_r == `FLB_IDX_CYCLIC |-> pos_r == pre_r[5:0];
  endproperty
  a_cyc_first: assert property (p_cyc_first) else $error("cyclic start pos");
  property p_wrap;
    push && idx_r >= `FLB_IDX_CYCLIC && pos_r == 6'h00 |=> pos_r == 6'h39;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap to 57");
  property p_reserved;
    push && idx_r >= `FLB_IDX_RESERVED |-> sel_byte == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved not zero");
  property p_end;
    push && idx_r == `FLB_IDX_LAST |=> st_r == flb_pkg::FLB_IDLE;
  endproperty
  a_end: assert property (p_end) else $error("block not 255 bytes");
  property p_lock;
    $fell(lock_r) |-> $past(done_r) && !$past(restore_done_i);
  endproperty
  a_lock: assert property (p_lock) else $error("lock cleared early");

  c_full_read: cover property (done_r);
  c_stall:     cover property (busy_o && !fifo_rdy);
  c_wrap:      cover property (push && pos_r == 6'h00 && idx_r > `FLB_IDX_CYCLIC);
  c_unlock:    cover property ($fell(lock_r));
endmodule : flb_readout

// ===== tb/flb_host_model.sv
// Host-side sink model that takes fault-log bytes promptly or with stalls
module flb_host_model (
  input  wire logic       clk_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       valid_i,
  input  wire logic       last_i,
  output logic            ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] got_q [$];
  logic [1:0] ph_r = 2'h0;
  initial ready_o = 1'b0;
  // Ready moves only at the falling edge; slow mode takes one beat in three
  always @(negedge clk_i) begin
    ph_r    <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
    ready_o <= !slow_i || (ph_r == 2'h1);
  end
  // Bytes are taken at the rising edge, where the block samples ready too
  always @(posedge clk_i) begin
    if (valid_i && ready_o) begin
      got_q.push_back({last_i, byte_i});
    end
  end
endmodule : flb_host_model

// ===== tb/test_flb_readout.sv
// Self-checking bench for the fault-log block readout
module test_flb_readout;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk_sys_i = 1'b0;
  logic         rstn_i = 1'b0;
  logic         rec_wr_i = 1'b0;
  logic         fault_i = 1'b0;
  logic         restore_done_i = 1'b0;
  logic         read_start_i = 1'b0;
  logic         slow = 1'b0;
  logic [5:0]   rec_pos_i = 6'h00;
  logic [7:0]   rec_data_i = 8'h00;
  logic [7:0]   fault_ptr_i = 8'h00;
  logic [383:0] chan_ext_i = '0;
  logic [95:0]  input_ext_i = '0;
  logic [95:0]  chan_status_i = '0;
  logic [7:0]   byte_o;
  logic         byte_valid_o, byte_last_o, byte_ready_i, busy_o, read_done_o, ram_lock_o;
  logic [575:0] snap;
  logic [7:0]   rec [58];
  logic [7:0]   ptr_s;
  logic [40:0]  tick_a, tick_b;
  int           fail_count = 0;
  int           checks_done = 0;
  int           cyc_cnt = 0;
  int           c_f, c_a;

  // Short tick period keeps the stamp moving within a short run
  flb_readout #(.TICK_CYCLES(4), .FIFO_DEPTH(8)) u_flb_readout (.clk_sys_i, .rstn_i,
    .rec_wr_i, .rec_pos_i, .rec_data_i, .fault_i, .fault_ptr_i, .chan_ext_i, .input_ext_i,
    .chan_status_i, .restore_done_i, .read_start_i, .byte_o, .byte_valid_o, .byte_last_o,
    .byte_ready_i, .busy_o, .read_done_o, .ram_lock_o);
  flb_host_model host (.clk_i(clk_sys_i), .slow_i(slow), .byte_i(byte_o),
    .valid_i(byte_valid_o), .last_i(byte_last_o), .ready_o(byte_ready_i));

  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc_cnt <= cyc_cnt + 1;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // Expected byte from the tb copy of the captured snapshot and the record
  function automatic logic [7:0] exp_byte(input int i);
    if (i == 0) return ptr_s;
    if (i < 19) return snap[(i-7)*8 +: 8];
    if (i < 31) return snap[384+(i-19)*8 +: 8];
    if (i < 67) return snap[96+(i-31)*8 +: 8];
    if (i < 79) return snap[480+(i-67)*8 +: 8];
    if (i < 238) return rec[(int'(ptr_s[5:0]) - (i - 79) + 174) % 58];
    return 8'h00;
  endfunction : exp_byte

  task automatic set_inputs(input logic [7:0] base);
    logic [575:0] v;
    for (int k = 0; k < 72; k++) v[k*8 +: 8] = base + 8'(k);
    {chan_status_i, input_ext_i, chan_ext_i} = v;
  endtask : set_inputs

  task automatic write_rec(input logic [5:0] p, input logic [7:0] d, input bit taken);
    @(negedge clk_sys_i);
    rec_wr_i = 1'b1;
    rec_pos_i = p;
    rec_data_i = d;
    if (taken) rec[p] = d;
    @(negedge clk_sys_i);
    rec_wr_i = 1'b0;
  endtask : write_rec

  // Live values change right after capture so a non-frozen snapshot shows up
  task automatic fault(input logic [7:0] ptr, input bit taken);
    @(negedge clk_sys_i);
    fault_i = 1'b1;
    fault_ptr_i = ptr;
    c_f = cyc_cnt;
    if (taken) begin
      ptr_s = ptr;
      snap = {chan_status_i, input_ext_i, chan_ext_i};
    end
    @(negedge clk_sys_i);
    fault_i = 1'b0;
    set_inputs(ptr + 8'h40);
  endtask : fault

  // One block read with a second start while busy, then a check of every byte but the tick stamp, which is returned in tk
  task automatic read_block(input logic s, output logic [40:0] tk);
    int n;
    host.got_q.delete();
    slow = s;
    @(negedge clk_sys_i);
    read_start_i = 1'b1;
    @(negedge clk_sys_i);
    read_start_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    read_start_i = 1'b1;
    @(negedge clk_sys_i);
    read_start_i = 1'b0;
    n = 0;
    while (read_done_o !== 1'b1) begin
      n++;
      if (n > 2000) begin
        fail_count++;
        summarize();
      end
      @(negedge clk_sys_i);
    end
    chk(9'(host.got_q.size()), 9'h0FF);
    for (int i = 0; i < 255; i++) begin
      if (i == 0 || i > 6) chk(host.got_q[i], {i == 254, exp_byte(i)});
    end
    chk(host.got_q[6] & 9'h1FE, 9'h000);
    tk = {host.got_q[6][0], host.got_q[5][7:0], host.got_q[4][7:0], host.got_q[3][7:0],
          host.got_q[2][7:0], host.got_q[1][7:0]};
    repeat (3) @(negedge clk_sys_i);
    chk({5'h00, byte_valid_o, read_done_o, busy_o, ram_lock_o}, 9'h000);
  endtask : read_block

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    repeat (6) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    chk({4'h0, byte_valid_o, byte_last_o, busy_o, read_done_o, ram_lock_o}, 9'h000);
    set_inputs(8'h10);
    for (int p = 0; p < 58; p++) write_rec(6'(p), 8'(p * 5 + 3), 1'b1);
    fault(8'h02, 1'b1);
    c_a = c_f;
    read_block(1'b1, tick_a);
    // Second capture lands a whole number of tick periods after the first;
    // the fault task waits one more edge before raising its strobe
    while ((cyc_cnt - c_a) % 4 != 3) @(negedge clk_sys_i);
    fault(8'h39, 1'b1);
    read_block(1'b0, tick_b);
    chk(9'(tick_b - tick_a), 9'((c_f - c_a) / 4));
    @(negedge clk_sys_i);
    restore_done_i = 1'b1;
    @(negedge clk_sys_i);
    restore_done_i = 1'b0;
    @(negedge clk_sys_i);
    chk({8'h00, ram_lock_o}, 9'h001);
    write_rec(6'h39, 8'hEE, 1'b0);
    fault(8'h05, 1'b0);
    read_block(1'b1, tick_a);
    summarize();
  end
endmodule : test_flb_readout
